// ---- rtl/tctfc_consts.vh ----
`ifndef TCTFC_CONSTS_VH
`define TCTFC_CONSTS_VH

// ********************************************
// register map, address width and field codes on the timer bus
// ********************************************
`define TCTFC_ADDR_W     5
`define TCTFC_CH_STAT    2'h3
`define TCTFC_SUB_CNT    2'h0
`define TCTFC_SUB_GRA    2'h1
`define TCTFC_SUB_GRB    2'h2
`define TCTFC_SUB_CTL    2'h3

// ********************************************
// reset values
// ********************************************
`define TCTFC_CNT_RST    16'h0000
`define TCTFC_GR_RST     16'hffff
`define TCTFC_CTL_RST    7'h00
`define TCTFC_CTL_FIXED  8'h80
`define TCTFC_STAT_FIXED 8'h88
`define TCTFC_FLAG_RST   3'h0

// ********************************************
// field positions
// ********************************************
`define TCTFC_CCLR_HI    6
`define TCTFC_CCLR_LO    5
`define TCTFC_EDGE_HI    4
`define TCTFC_EDGE_LO    3
`define TCTFC_PSC_HI     2
`define TCTFC_PSC_LO     0
`define TCTFC_EN_HI      6
`define TCTFC_EN_LO      4
`define TCTFC_FLAG_HI    2
`define TCTFC_FLAG_LO    0
`define TCTFC_IO_CAP     2

// ********************************************
// encodings and counts
// ********************************************
`define TCTFC_CLR_A      2'b01
`define TCTFC_CLR_B      2'b10
`define TCTFC_CLR_SYNC   2'b11
`define TCTFC_EDGE_RISE  2'b00
`define TCTFC_EDGE_FALL  2'b01
`define TCTFC_CAP_RISE   2'b00
`define TCTFC_CAP_FALL   2'b01
`define TCTFC_CAP_BOTH   2'b10
`define TCTFC_CNT_MAX    16'hffff
`define TCTFC_CNT_MIN    16'h0000
`define TCTFC_DIV_W      3

`endif

// ---- rtl/tctfc_edge.v ----
`timescale 1ns/1ps
`include "tctfc_consts.vh"

// ********************************************
// pin synchroniser with edge detection
// ********************************************
module tctfc_edge (
  // clock and reset
  input  wire mclk_i,
  input  wire nrst_i,
  // pin
  input  wire pin_i,
  // synchronised level and edges
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // two-stage sync, third stage only for edge detection
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // one pulse per edge, never from meta_q
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;

endmodule // tctfc_edge

// ---- rtl/tctfc_chan.v ----
`timescale 1ns/1ps
`include "tctfc_consts.vh"

// ********************************************
// one channel: counter and two general registers
// ********************************************
module tctfc_chan (
  // clock and reset
  input  wire        mclk_i,
  input  wire        nrst_i,
  input  wire        standby_i,
  // count strobes, already qualified by start
  input  wire        inc_i,
  input  wire        dec_i,
  // clear and function select
  input  wire [1:0]  clr_sel_i,
  input  wire        sync_clr_i,
  input  wire        oc_a_i,
  input  wire        oc_b_i,
  input  wire        cap_a_i,
  input  wire        cap_b_i,
  // bus write
  input  wire [15:0] wdata_i,
  input  wire [1:0]  wmask_i,
  input  wire        we_cnt_i,
  input  wire        we_a_i,
  input  wire        we_b_i,
  // state and events
  output wire [15:0] cnt_o,
  output wire [15:0] gra_o,
  output wire [15:0] grb_o,
  output wire        evt_a_o,
  output wire        evt_b_o,
  output wire        own_clr_o,
  output wire        wrap_up_o,
  output wire        wrap_dn_o
);

  reg  [15:0] cnt_q;
  reg  [15:0] gra_q;
  reg  [15:0] grb_q;
  wire        tick;
  wire        take_a;
  wire        take_b;
  wire        clr;

  // byte-lane merge for word and byte writes
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  m;
    begin
      merge = {m[1] ? nw[15:8] : old[15:8], m[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // compare on each count, capture on qualified edge
  assign tick    = inc_i | dec_i;
  assign take_a  = ~oc_a_i & cap_a_i;
  assign take_b  = ~oc_b_i & cap_b_i;
  assign evt_a_o = (oc_a_i & tick & (cnt_q == gra_q)) | take_a;
  assign evt_b_o = (oc_b_i & tick & (cnt_q == grb_q)) | take_b;

  // clear source select; sync clear comes from the group
  assign own_clr_o = ((clr_sel_i == `TCTFC_CLR_A) & evt_a_o) |
                     ((clr_sel_i == `TCTFC_CLR_B) & evt_b_o);
  assign clr       = own_clr_o | ((clr_sel_i == `TCTFC_CLR_SYNC) & sync_clr_i);

  // wrap events, suppressed when the count is cleared instead
  assign wrap_up_o = inc_i & ~clr & ~we_cnt_i & (cnt_q == `TCTFC_CNT_MAX);
  assign wrap_dn_o = dec_i & ~clr & ~we_cnt_i & (cnt_q == `TCTFC_CNT_MIN);

  // counter: write beats clear beats count
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= `TCTFC_CNT_RST;
    end else if (standby_i) begin
      cnt_q <= `TCTFC_CNT_RST;
    end else if (we_cnt_i) begin
      cnt_q <= merge(cnt_q, wdata_i, wmask_i);
    end else if (clr) begin
      cnt_q <= `TCTFC_CNT_RST;
    end else if (inc_i) begin
      cnt_q <= cnt_q + 16'h0001;
    end else if (dec_i) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // general registers; a capture outranks a bus write
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gra_q <= `TCTFC_GR_RST;
      grb_q <= `TCTFC_GR_RST;
    end else if (standby_i) begin
      gra_q <= `TCTFC_GR_RST;
      grb_q <= `TCTFC_GR_RST;
    end else begin
      if (take_a) begin
        gra_q <= cnt_q;
      end else if (we_a_i) begin
        gra_q <= merge(gra_q, wdata_i, wmask_i);
      end
      if (take_b) begin
        grb_q <= cnt_q;
      end else if (we_b_i) begin
        grb_q <= merge(grb_q, wdata_i, wmask_i);
      end
    end
  end

  assign cnt_o = cnt_q;
  assign gra_o = gra_q;
  assign grb_o = grb_q;

endmodule // tctfc_chan

// ---- rtl/tctfc_top.v ----
// Operation
// - match-B enable gates match-B interrupt, resets 0
// - match-B flag clears after read-one, write-zero
// - compare function: counter equals B sets flag
// - capture function: capture into B sets flag
// - overflow status resets 0x88, bits 7,3 one
// - wrap enable gates wrap interrupt, resets 0
// - wrap flag clears after read-one, write-zero
// - flag bits accept only zero writes
// - channels 0,1 wrap flag on ffff to 0
// - channel 2 also flags underflow 0 to ffff
// - direction bit 1 limits channel 2 to overflow
// - 16-bit counters, selected source, reset 0
// - only channel 2 counts down, phase mode only
// - phase mode decodes clock pins A,B
// - clear field: none, A event, B event
// - clear event follows compare or capture function
// - code 11 clears with synchronised channels
// - counters, general registers: word or byte access
// - general registers reset ffff, compare, no output
// - compare match sets compare flag per count
// - capture stores counter, sets flag same cycle
// - pwm mode ignores io control settings
// - control registers reset 0x80, bit 7 one
// - edge field: rising, falling, both edges
// - phase mode overrides channel 2 edge and prescale fields
// - prescale: phi, /2, /4, /8, pins A-D
`timescale 1ns/1ps
`include "tctfc_consts.vh"

module tctfc_top (
  // clock and reset
  input  wire                     mclk_i,
  input  wire                     nrst_i,
  input  wire                     standby_i,
  // internal register bus
  input  wire [`TCTFC_ADDR_W-1:0] addr_i,
  input  wire                     wr_i,
  input  wire                     rd_i,
  input  wire                     byte_i,
  input  wire [15:0]              wdata_i,
  output wire [15:0]              rdata_o,
  // mode and sync settings
  input  wire [2:0]               start_i,
  input  wire [2:0]               channel_sync_select_i,
  input  wire                     phase_count_mode_i,
  input  wire                     wrap_flag_direction_i,
  input  wire [2:0]               pwm_mode_i,
  input  wire [8:0]               io_ctl_a_i,
  input  wire [8:0]               io_ctl_b_i,
  // timer pins
  input  wire [3:0]               ext_clk_i,
  input  wire [2:0]               cap_pin_a_i,
  input  wire [2:0]               cap_pin_b_i,
  // interrupt requests
  output wire [2:0]               match_b_irq_o,
  output wire [2:0]               wrap_irq_o
);

  // ********************************************
  // declarations
  // ********************************************
  reg  [15:0] rdata_q;
  reg  [2:0]  mb_irq_q;
  reg  [2:0]  wr_irq_q;
  reg  [2:0]  mb_flag_q;
  reg  [2:0]  mb_en_q;
  reg  [2:0]  mb_arm_q;
  reg  [2:0]  wf_flag_q;
  reg  [2:0]  wf_en_q;
  reg  [2:0]  wf_arm_q;
  reg  [2:0]  mb_flag_d;
  reg  [2:0]  mb_en_d;
  reg  [2:0]  mb_arm_d;
  reg  [2:0]  wf_flag_d;
  reg  [2:0]  wf_en_d;
  reg  [2:0]  wf_arm_d;
  reg  [`TCTFC_DIV_W-1:0] div_q;
  reg  [6:0]  ctl_q [0:2];
  reg  [15:0] slot_val;

  wire [9:0]  pin_all;
  wire [9:0]  pin_lvl;
  wire [9:0]  pin_rise;
  wire [9:0]  pin_fall;
  wire [3:0]  div_en;
  wire [1:0]  ch_sel;
  wire [1:0]  sub_sel;
  wire [1:0]  wmask;
  wire [15:0] wdat;
  wire        stat_hit;
  wire [47:0] cnt_w;
  wire [47:0] gra_w;
  wire [47:0] grb_w;
  wire [2:0]  evt_a;
  wire [2:0]  evt_b;
  wire [2:0]  own_clr;
  wire [2:0]  wrap_up;
  wire [2:0]  wrap_dn;
  wire [2:0]  cnt_hit;
  wire [2:0]  we_cnt;
  wire [2:0]  inc;
  wire [2:0]  dec;
  wire        sync_clr;
  wire        ph_up;
  wire        ph_dn;
  wire [2:0]  mb_clr;
  wire [2:0]  wf_clr;
  wire [2:0]  wf_set;

  // ********************************************
  // decode helpers
  // ********************************************

  // count source: internal enables or chosen pin edges
  function tick_sel;
    input [6:0] ctl;
    input [3:0] dv;
    input [3:0] r;
    input [3:0] f;
    reg   [1:0] s;
    reg   [1:0] e;
    begin
      s = ctl[`TCTFC_PSC_HI-1:`TCTFC_PSC_LO];
      e = ctl[`TCTFC_EDGE_HI:`TCTFC_EDGE_LO];
      if (!ctl[`TCTFC_PSC_HI]) begin
        tick_sel = dv[s];
      end else if (e == `TCTFC_EDGE_RISE) begin
        tick_sel = r[s];
      end else if (e == `TCTFC_EDGE_FALL) begin
        tick_sel = f[s];
      end else begin
        tick_sel = r[s] | f[s];
      end
    end
  endfunction

  // capture edge from io code; compare codes never capture
  function cap_sel;
    input [2:0] io;
    input       r;
    input       f;
    begin
      case (io[1:0])
        `TCTFC_CAP_RISE: cap_sel = io[`TCTFC_IO_CAP] & r;
        `TCTFC_CAP_FALL: cap_sel = io[`TCTFC_IO_CAP] & f;
        `TCTFC_CAP_BOTH: cap_sel = io[`TCTFC_IO_CAP] & (r | f);
        default:         cap_sel = 1'b0;
      endcase
    end
  endfunction

  // ********************************************
  // pin synchronisers
  // ********************************************

  // order: ext clocks A-D, capture A0-A2, capture B0-B2
  assign pin_all = {cap_pin_b_i, cap_pin_a_i, ext_clk_i};

  genvar gp;
  generate
    for (gp = 0; gp < 10; gp = gp + 1) begin : g_pin
      tctfc_edge u_edge (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .pin_i   (pin_all[gp]),
        .level_o (pin_lvl[gp]),
        .rise_o  (pin_rise[gp]),
        .fall_o  (pin_fall[gp])
      );
    end
  endgenerate

  // ********************************************
  // prescaler and phase decoder
  // ********************************************

  // free-running divider gives one-cycle phi/2, /4, /8 enables
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= {`TCTFC_DIV_W{1'b0}};
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  assign div_en = {&div_q, &div_q[1:0], div_q[0], 1'b1};

  // quadrature on clock pins A,B; every edge of both counts
  assign ph_up = (pin_rise[1] & ~pin_lvl[0]) | (pin_rise[0] & pin_lvl[1]) |
                 (pin_fall[1] & pin_lvl[0]) | (pin_fall[0] & ~pin_lvl[1]);
  assign ph_dn = (pin_rise[0] & ~pin_lvl[1]) | (pin_rise[1] & pin_lvl[0]) |
                 (pin_fall[0] & pin_lvl[1]) | (pin_fall[1] & ~pin_lvl[0]);

  // ********************************************
  // bus decode
  // ********************************************

  // big-endian lanes: even byte is the upper half
  assign ch_sel   = addr_i[4:3];
  assign sub_sel  = addr_i[2:1];
  assign wmask    = byte_i ? (addr_i[0] ? 2'b01 : 2'b10) : 2'b11;
  assign wdat     = byte_i ? {wdata_i[7:0], wdata_i[7:0]} : wdata_i;
  assign stat_hit = (ch_sel == `TCTFC_CH_STAT) & (sub_sel == 2'b00);

  // a clear of one synced counter clears every synced counter set to code 11
  assign sync_clr = |(own_clr & channel_sync_select_i);

  // ********************************************
  // channels
  // ********************************************
  genvar gc;
  generate
    for (gc = 0; gc < 3; gc = gc + 1) begin : g_ch
      wire hit_ch;
      wire oc_a;
      wire oc_b;
      assign hit_ch = wr_i & (ch_sel == gc);
      assign cnt_hit[gc] = hit_ch & (sub_sel == `TCTFC_SUB_CNT);
      assign we_cnt[gc]  = cnt_hit[gc] |
                           (channel_sync_select_i[gc] & |(cnt_hit & channel_sync_select_i));
      // pwm mode forces both general registers to compare
      assign oc_a = pwm_mode_i[gc] | ~io_ctl_a_i[3*gc+2];
      assign oc_b = pwm_mode_i[gc] | ~io_ctl_b_i[3*gc+2];

      // channel 2 in phase mode counts both ways
      if (gc == 2) begin : g_ph
        assign inc[gc] = start_i[gc] &
                         (phase_count_mode_i ? ph_up :
                          tick_sel(ctl_q[gc], div_en, pin_rise[3:0], pin_fall[3:0]));
        assign dec[gc] = start_i[gc] & phase_count_mode_i & ph_dn;
      end else begin : g_up
        assign inc[gc] = start_i[gc] &
                         tick_sel(ctl_q[gc], div_en, pin_rise[3:0], pin_fall[3:0]);
        assign dec[gc] = 1'b0;
      end

      // control register, bit 7 fixed at one
      always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          ctl_q[gc] <= `TCTFC_CTL_RST;
        end else if (standby_i) begin
          ctl_q[gc] <= `TCTFC_CTL_RST;
        end else if (hit_ch & (sub_sel == `TCTFC_SUB_CTL) & wmask[1]) begin
          ctl_q[gc] <= wdat[14:8];
        end
      end

      tctfc_chan u_chan (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .standby_i  (standby_i),
        .inc_i      (inc[gc]),
        .dec_i      (dec[gc]),
        .clr_sel_i  (ctl_q[gc][`TCTFC_CCLR_HI:`TCTFC_CCLR_LO]),
        .sync_clr_i (sync_clr & channel_sync_select_i[gc]),
        .oc_a_i     (oc_a),
        .oc_b_i     (oc_b),
        .cap_a_i    (cap_sel(io_ctl_a_i[3*gc+2 -: 3], pin_rise[4+gc], pin_fall[4+gc])),
        .cap_b_i    (cap_sel(io_ctl_b_i[3*gc+2 -: 3], pin_rise[7+gc], pin_fall[7+gc])),
        .wdata_i    (wdat),
        .wmask_i    (wmask),
        .we_cnt_i   (we_cnt[gc]),
        .we_a_i     (hit_ch & (sub_sel == `TCTFC_SUB_GRA)),
        .we_b_i     (hit_ch & (sub_sel == `TCTFC_SUB_GRB)),
        .cnt_o      (cnt_w[16*gc+15 -: 16]),
        .gra_o      (gra_w[16*gc+15 -: 16]),
        .grb_o      (grb_w[16*gc+15 -: 16]),
        .evt_a_o    (evt_a[gc]),
        .evt_b_o    (evt_b[gc]),
        .own_clr_o  (own_clr[gc]),
        .wrap_up_o  (wrap_up[gc]),
        .wrap_dn_o  (wrap_dn[gc])
      );
    end
  endgenerate

  // ********************************************
  // status flags and enables
  // ********************************************

  // zero written to an armed flag clears it; ones do nothing
  assign mb_clr = {3{wr_i & stat_hit & wmask[1]}} & mb_arm_q & ~wdat[10:8];
  assign wf_clr = {3{wr_i & stat_hit & wmask[0]}} & wf_arm_q & ~wdat[2:0];

  // channel 2 also flags underflow unless direction bit set
  assign wf_set = wrap_up | {wrap_dn[2] & ~wrap_flag_direction_i, 2'b00};

  // next state; a set in the clearing cycle wins
  always @* begin
    mb_flag_d = (mb_flag_q & ~mb_clr) | evt_b;
    wf_flag_d = (wf_flag_q & ~wf_clr) | wf_set;
    mb_en_d   = mb_en_q;
    wf_en_d   = wf_en_q;
    mb_arm_d  = mb_arm_q & mb_flag_q;
    wf_arm_d  = wf_arm_q & wf_flag_q;
    if (standby_i) begin
      mb_flag_d = `TCTFC_FLAG_RST;
      wf_flag_d = `TCTFC_FLAG_RST;
      mb_en_d   = `TCTFC_FLAG_RST;
      wf_en_d   = `TCTFC_FLAG_RST;
      mb_arm_d  = `TCTFC_FLAG_RST;
      wf_arm_d  = `TCTFC_FLAG_RST;
    end else if (wr_i & stat_hit) begin
      if (wmask[1]) begin
        mb_en_d  = wdat[14:12];
        mb_arm_d = `TCTFC_FLAG_RST;
      end
      if (wmask[0]) begin
        wf_en_d  = wdat[6:4];
        wf_arm_d = `TCTFC_FLAG_RST;
      end
    end else if (rd_i & stat_hit) begin
      // a read arms only the flags that are one right now
      if (wmask[1]) begin
        mb_arm_d = mb_flag_q;
      end
      if (wmask[0]) begin
        wf_arm_d = wf_flag_q;
      end
    end
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mb_flag_q <= `TCTFC_FLAG_RST;
      mb_en_q   <= `TCTFC_FLAG_RST;
      mb_arm_q  <= `TCTFC_FLAG_RST;
      wf_flag_q <= `TCTFC_FLAG_RST;
      wf_en_q   <= `TCTFC_FLAG_RST;
      wf_arm_q  <= `TCTFC_FLAG_RST;
    end else begin
      mb_flag_q <= mb_flag_d;
      mb_en_q   <= mb_en_d;
      mb_arm_q  <= mb_arm_d;
      wf_flag_q <= wf_flag_d;
      wf_en_q   <= wf_en_d;
      wf_arm_q  <= wf_arm_d;
    end
  end

  // requests track flag and enable with no extra cycle of lag
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mb_irq_q <= 3'h0;
      wr_irq_q <= 3'h0;
    end else begin
      mb_irq_q <= mb_flag_d & mb_en_d;
      wr_irq_q <= wf_flag_d & wf_en_d;
    end
  end

  // ********************************************
  // read path
  // ********************************************

  // slot value; unmapped addresses read zero
  always @* begin
    slot_val = 16'h0000;
    if (ch_sel == `TCTFC_CH_STAT) begin
      if (sub_sel == 2'b00) begin
        slot_val = {`TCTFC_STAT_FIXED | {1'b0, mb_en_q, 1'b0, mb_flag_q},
                    `TCTFC_STAT_FIXED | {1'b0, wf_en_q, 1'b0, wf_flag_q}};
      end
    end else begin
      case (sub_sel)
        `TCTFC_SUB_CNT: slot_val = cnt_w[16*ch_sel+15 -: 16];
        `TCTFC_SUB_GRA: slot_val = gra_w[16*ch_sel+15 -: 16];
        `TCTFC_SUB_GRB: slot_val = grb_w[16*ch_sel+15 -: 16];
        `TCTFC_SUB_CTL: slot_val = {`TCTFC_CTL_FIXED | {1'b0, ctl_q[ch_sel]}, 8'h00};
        default:        slot_val = 16'h0000;
      endcase
    end
  end

  // read data held until the next read
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 16'h0000;
    end else if (rd_i) begin
      if (!byte_i) begin
        rdata_q <= slot_val;
      end else if (addr_i[0]) begin
        rdata_q <= {8'h00, slot_val[7:0]};
      end else begin
        rdata_q <= {8'h00, slot_val[15:8]};
      end
    end
  end

  assign rdata_o       = rdata_q;
  assign match_b_irq_o = mb_irq_q;
  assign wrap_irq_o    = wr_irq_q;

endmodule // tctfc_top

// ---- bench/tctfc_pins.sv ----
`timescale 1ns/1ps
// ****************************************
// timer pin driver
// ****************************************
module tctfc_pins (
  input  wire        mclk_i,
  output logic [3:0] ext_clk_o,
  output logic [2:0] cap_b_o
);
  // pins idle low
  initial begin
    ext_clk_o = 4'h0;
    cap_b_o   = 3'h0;
  end
  // each level held 6 cycles, so the two-flop sync never misses it
  task automatic put(input logic [3:0] c, input logic [2:0] b);
    @(negedge mclk_i);
    ext_clk_o = c;
    cap_b_o   = b;
    repeat (6) @(negedge mclk_i);
  endtask
endmodule // tctfc_pins

// ---- bench/tctfc_top_checker.sv ----
`timescale 1ns/1ps
`include "tctfc_consts.vh"
// ****************************************
// port checker
// ****************************************
module tctfc_top_checker (
  input wire                     mclk_i,
  input wire                     nrst_i,
  input wire                     standby_i,
  input wire [`TCTFC_ADDR_W-1:0] addr_i,
  input wire                     wr_i,
  input wire                     rd_i,
  input wire                     byte_i,
  input wire [15:0]              wdata_i,
  input wire [15:0]              rdata_o,
  input wire [2:0]               match_b_irq_o,
  input wire [2:0]               wrap_irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // any write touching either status byte
  wire stat_wr = wr_i && addr_i[4:1] == 4'hc;
  stat_fixed_a: assert property (rd_i && byte_i && addr_i[4:1] == 4'hc |=>
    rdata_o[7] && rdata_o[3] && rdata_o[15:8] == 8'h00) else $error("status fixed bits");
  ctl_fixed_a: assert property (rd_i && byte_i && addr_i[2:0] == 3'h6 &&
    addr_i[4:3] != 2'h3 |=> rdata_o[7]) else $error("control bit 7 not one");
  wrap_mask_a: assert property (wr_i && byte_i && addr_i == 5'h19 &&
    wdata_i[6:4] == 3'h0 |=> wrap_irq_o == 3'h0) else $error("wrap irq not masked");
  b_mask_a: assert property (wr_i && byte_i && addr_i == 5'h18 &&
    wdata_i[6:4] == 3'h0 |=> match_b_irq_o == 3'h0) else $error("match irq not masked");
  standby_irq_a: assert property (standby_i |=>
    match_b_irq_o == 3'h0 && wrap_irq_o == 3'h0) else $error("irq after standby");
  rdata_hold_a: assert property (!rd_i && !standby_i |=> $stable(rdata_o))
    else $error("read data moved");
  wrap_fall_a: assert property (|($past(wrap_irq_o) & ~wrap_irq_o) |->
    $past(stat_wr) || $past(standby_i)) else $error("wrap irq fell alone");
  b_fall_a: assert property (|($past(match_b_irq_o) & ~match_b_irq_o) |->
    $past(stat_wr) || $past(standby_i)) else $error("match irq fell alone");
endmodule // tctfc_top_checker

bind tctfc_top tctfc_top_checker chk_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .standby_i(standby_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .byte_i(byte_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .match_b_irq_o(match_b_irq_o),
  .wrap_irq_o(wrap_irq_o));

// ---- bench/tb_three_channel_timer_flags_counters.sv ----
`timescale 1ns/1ps
module tb_three_channel_timer_flags_counters;
  logic mclk_i = 0, nrst_i = 0, standby_i = 0, wr_i = 0, rd_i = 0, byte_i = 0;
  logic pm = 0, wrap_flag_direction = 0;
  logic [2:0] sync = 3'h0, pwm = 3'h0;
  logic [4:0] addr_i = 5'h00;
  logic [15:0] wdata_i = 16'h0000, r;
  logic [2:0] start_i = 3'h0, iob = 3'h0, capb, mb_irq, wr_irq;
  logic [3:0] xclk;
  wire [15:0] rdata_o;
  int n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h7e6fa692;
  // ****************************************
  // design and pins
  // ****************************************
  always #5 mclk_i = ~mclk_i;
  tctfc_pins pins (.mclk_i(mclk_i), .ext_clk_o(xclk), .cap_b_o(capb));
  tctfc_top dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .standby_i(standby_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .byte_i(byte_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .start_i(start_i), .channel_sync_select_i(sync), .phase_count_mode_i(pm),
    .wrap_flag_direction_i(wrap_flag_direction), .pwm_mode_i(pwm), .io_ctl_a_i(9'h000),
    .io_ctl_b_i({6'h00, iob}), .ext_clk_i(xclk), .cap_pin_a_i(3'h0),
    .cap_pin_b_i(capb), .match_b_irq_o(mb_irq), .wrap_irq_o(wr_irq));
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done;
    end
  end
  task test_done;
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  // one-cycle strobe, then released on the next falling edge
  task bus(input logic w, input logic [4:0] a, input logic b, input logic [15:0] d);
    @(negedge mclk_i);
    addr_i = a;
    byte_i = b;
    wdata_i = d;
    wr_i = w;
    rd_i = !w;
    @(negedge mclk_i);
    wr_i = 0;
    rd_i = 0;
  endtask
  task rdc(input logic [4:0] a, input logic b, input logic [15:0] e);
    bus(0, a, b, 16'h0000);
    chk(rdata_o, e);
  endtask
  initial begin
    repeat (8) @(negedge mclk_i);
    nrst_i = 1;
    for (int c = 0; c < 3; c++) begin
      rdc(5'(8 * c), 0, 16'h0000);
      rdc(5'(8 * c + 2), 0, 16'hffff);
      rdc(5'(8 * c + 4), 0, 16'hffff);
      rdc(5'(8 * c + 6), 1, 16'h0080);
    end
    rdc(5'h18, 1, 16'h0088);
    rdc(5'h19, 1, 16'h0088);
    rdc(5'h1c, 0, 16'h0000);
    r = 16'($random(seed));
    bus(1, 5'h02, 0, r);
    rdc(5'h02, 0, r);
    bus(1, 5'h03, 1, {8'h00, ~r[7:0]});
    rdc(5'h02, 0, {r[15:8], ~r[7:0]});
    rdc(5'h02, 1, {8'h00, r[15:8]});
    // channel 0 runs over ffff; gen B still ffff, so it matches on the way
    bus(1, 5'h00, 0, 16'hfffd);
    start_i = 3'h1;
    repeat (6) @(negedge mclk_i);
    start_i = 3'h0;
    bus(1, 5'h19, 1, 16'h0010);
    chk({13'h0, wr_irq}, 16'h0001);
    bus(1, 5'h19, 1, 16'h0017);
    rdc(5'h19, 1, 16'h0099);
    bus(1, 5'h19, 1, 16'h0010);
    chk({13'h0, wr_irq}, 16'h0000);
    // channel 1 periodic, cleared on gen B match at 5
    bus(1, 5'h0c, 0, 16'h0005);
    bus(1, 5'h0e, 1, 16'h0040);
    bus(1, 5'h08, 0, 16'h0000);
    bus(1, 5'h18, 1, 16'h0020);
    start_i = 3'h2;
    repeat (20) @(negedge mclk_i);
    start_i = 3'h0;
    chk({13'h0, mb_irq}, 16'h0002);
    bus(0, 5'h08, 0, 16'h0000);
    chk({15'h0, rdata_o < 16'h0006}, 16'h0001);
    rdc(5'h18, 1, 16'h00ab);
    bus(1, 5'h18, 1, 16'h0020);
    chk({13'h0, mb_irq}, 16'h0000);
    // capture on channel 0 gen B, counter halted
    bus(1, 5'h00, 0, 16'h1234);
    iob = 3'b100;
    pins.put(4'h0, 3'h1);
    pins.put(4'h0, 3'h0);
    rdc(5'h04, 0, 16'h1234);
    rdc(5'h18, 1, 16'h00a9);
    // sync group: preset reaches both, code 11 follows channel 0's capture clear
    sync = 3'h3;
    bus(1, 5'h00, 0, 16'h0abc);
    rdc(5'h08, 0, 16'h0abc);
    bus(1, 5'h06, 1, 16'h0040);
    bus(1, 5'h0e, 1, 16'h0060);
    pins.put(4'h0, 3'h1);
    pins.put(4'h0, 3'h0);
    rdc(5'h08, 0, 16'h0000);
    rdc(5'h00, 0, 16'h0000);
    rdc(5'h04, 0, 16'h0abc);
    // pwm forces compare, so the capture pin must be ignored
    pwm = 3'h1;
    bus(1, 5'h00, 0, 16'h0055);
    pins.put(4'h0, 3'h1);
    pins.put(4'h0, 3'h0);
    pwm = 3'h0;
    sync = 3'h0;
    rdc(5'h04, 0, 16'h0abc);
    // channel 1 on pin C: falling edges only, then both edges
    for (int m = 0; m < 2; m++) begin
      bus(1, 5'h0e, 1, 16'(8'h0e + 8 * m));
      bus(1, 5'h08, 0, 16'h0000);
      start_i = 3'h2;
      pins.put(4'h4, 3'h0);
      pins.put(4'h0, 3'h0);
      start_i = 3'h0;
      rdc(5'h08, 0, 16'(m + 1));
    end
    // phi/8: any 16 cycles hold exactly two enable pulses
    bus(1, 5'h0e, 1, 16'h0003);
    bus(1, 5'h08, 0, 16'h0000);
    start_i = 3'h2;
    repeat (16) @(negedge mclk_i);
    start_i = 3'h0;
    rdc(5'h08, 0, 16'h0002);
    // channel 2 phase counting: down, up, then down with overflow-only flagging
    pm = 1;
    start_i = 3'h4;
    pins.put(4'h1, 3'h0);
    rdc(5'h10, 0, 16'hffff);
    rdc(5'h19, 1, 16'h009c);
    bus(1, 5'h19, 1, 16'h0010);
    wrap_flag_direction = 1;
    pins.put(4'h0, 3'h0);
    rdc(5'h19, 1, 16'h009c);
    bus(1, 5'h19, 1, 16'h0010);
    pins.put(4'h1, 3'h0);
    rdc(5'h10, 0, 16'hffff);
    rdc(5'h19, 1, 16'h0098);
    start_i = 3'h0;
    bus(1, 5'h18, 1, 16'h0000);
    bus(1, 5'h19, 1, 16'h0000);
    standby_i = 1;
    @(negedge mclk_i);
    standby_i = 0;
    rdc(5'h00, 0, 16'h0000);
    rdc(5'h04, 0, 16'hffff);
    test_done;
  end
endmodule // tb_three_channel_timer_flags_counters
